// *** sdram_timing_regs.svh ***
// named encodings, field positions and reset values for the sdram command timing block
`ifndef SDRAM_TIMING_REGS_SVH
`define SDRAM_TIMING_REGS_SVH

// ras/cas/we encodings with chip select low
`define SDT_ENC_MODE 3'h0
`define SDT_ENC_REFRESH 3'h1
`define SDT_ENC_PRE 3'h2
`define SDT_ENC_ACT 3'h3
`define SDT_ENC_WRITE 3'h4
`define SDT_ENC_READ 3'h5

// address bit that selects auto precharge or all banks
`define SDT_AP_BIT 10

// mode register field positions
`define SDT_MODE_BL_LSB 0
`define SDT_MODE_BL_MSB 2
`define SDT_MODE_BT_BIT 3
`define SDT_MODE_CL_LSB 4
`define SDT_MODE_CL_MSB 6

// cas latency codes that the array supports
`define SDT_CL_TWO 3'h2
`define SDT_CL_THREE 3'h3

// column bits that address the flop array inside one bank
`define SDT_COL_MSB 2

// reset values of the mode state
`define SDT_RST_BL_CODE 2'h0
`define SDT_RST_CL3 1'h0
`define SDT_RST_INTERLEAVE 1'h0

`endif

// *** sdram_timing_pkg.sv ***
// types shared by the sdram command timing block
package sdram_timing_pkg;

  // decoded command of one link clock edge
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_PRE,
    CMD_READ,
    CMD_WRITE,
    CMD_REFRESH,
    CMD_SELF_REF,
    CMD_MODE
  } cmd_type;

  // command and address pins sampled together
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank;
    logic [10:0] addr;
  } link_cmd_type;

  // state reported into the system clock domain
  typedef struct packed {
    logic [1:0] bank_open;
    logic self_ref;
    logic cl3;
    logic cmd_tgl;
  } link_status_type;

endpackage : sdram_timing_pkg

// *** sdram_cdc_sync.sv ***
// two flop level synchroniser
module sdram_cdc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset of the receiving domain
  input wire logic i_clk,
  input wire logic i_rst,
  // level from the other domain
  input wire logic [WIDTH-1:0] i_d,
  // synchronised level
  output logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_q; // first stage, read only by the second

  // both stages clear together; the first is never looked at elsewhere
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule : sdram_cdc_sync

// *** sdram_command_timing.sv ***
// device side command decode, burst engine and data latency of a two bank sdram
`include "sdram_timing_regs.svh"

module sdram_command_timing (
  // system clock domain
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // link clock from the controller
  input wire logic i_clk_link,
  // command, clock enable and byte masks
  input wire logic i_cke,
  input wire sdram_timing_pkg::link_cmd_type i_cmd,
  input wire logic [7:0] i_dqm,
  // data pins
  input wire logic [63:0] i_dq_i,
  output logic [63:0] o_dq_o,
  output logic [7:0] o_dq_oe_n,
  // status in the system domain
  output logic [1:0] o_bank_open,
  output logic o_self_ref,
  output logic o_cl3,
  output logic o_cmd_pulse
);

  // column offset inside a burst, sequential or interleaved
  function automatic logic [2:0] burst_col(input logic [2:0] start, input logic [2:0] cnt,
                                           input logic [1:0] code, input logic ilv);
    logic [2:0] mask;
    logic [2:0] sum;
    mask = 3'(({1'b0, 3'h0} | (4'h1 << code)) - 4'h1);
    sum = 3'(start + cnt);
    if (ilv) begin
      burst_col = start ^ (cnt & mask);
    end else begin
      burst_col = (start & ~mask) | (sum & mask);
    end
  endfunction : burst_col

  // burst length in beats from the mode code
  function automatic logic [3:0] burst_len(input logic [1:0] code);
    burst_len = 4'h1 << code;
  endfunction : burst_len

  logic lrst; // system reset carried into the link domain
  logic cke_q; // clock enable seen at the previous edge
  logic clk_act; // internal clock running this edge
  sdram_timing_pkg::cmd_type cmd; // decoded command
  logic self_ref_q; // in self refresh
  logic [1:0] bank_open_q; // row open per bank
  logic [1:0] bl_code_q; // burst length code
  logic ilv_q; // interleaved burst order
  logic cl3_q; // cas latency three
  logic [3:0] burst_left_q; // beats still due
  logic [2:0] burst_cnt_q; // beat number of the next beat
  logic [2:0] start_col_q; // starting column of the burst
  logic burst_bank_q; // bank of the burst
  logic burst_wr_q; // burst is a write
  logic burst_ap_q; // burst closes its row at the end
  logic is_col; // read or write accepted now
  logic term; // precharge hits the running burst
  logic beat_v; // a data beat happens this edge
  logic beat_wr; // the beat is a write
  logic [3:0] beat_idx; // array index of the beat
  logic [63:0] mem_q [16]; // data array, bank and low column
  logic [1:0] pipe_v_q; // read beats in flight
  logic [3:0] pipe_idx_q [2]; // their array indices
  logic [7:0] dqm_q; // byte masks one edge old
  logic tap_v; // read beat due on the pins next
  logic [3:0] tap_idx; // its index
  logic cmd_tgl_q; // flips on every accepted command
  sdram_timing_pkg::link_status_type stat_link; // status leaving the link domain
  sdram_timing_pkg::link_status_type stat_sys; // status after the synchroniser
  logic tgl_old_q; // previous synchronised toggle
  logic [3:0] chk_idx_q; // helper: last beat index
  logic [7:0] chk_old_q; // helper: byte zero before the beat
  logic [7:0] chk_din_q; // helper: byte zero presented with the beat
  logic chk_bank_q; // helper: bank of the last command

  // the link side needs its own reset, so the system reset is carried across
  sdram_cdc_sync #(.WIDTH(1)) u_rst_sync (
    .i_clk(i_clk_link),
    .i_rst(1'b0),
    .i_d(i_sys_rst),
    .o_q(lrst)
  );

  // clock enable takes effect one edge after it is sampled
  always_ff @(posedge i_clk_link) begin
    if (lrst) begin
      cke_q <= 1'b1;
    end else begin
      cke_q <= i_cke;
    end
  end
  assign clk_act = cke_q;

  // command decode; chip select high makes the edge a no-op at once
  always_comb begin
    cmd = sdram_timing_pkg::CMD_NOP;
    if (clk_act && !self_ref_q && !i_cmd.cs_n) begin
      case ({i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n})
        `SDT_ENC_ACT: cmd = sdram_timing_pkg::CMD_ACT;
        `SDT_ENC_PRE: cmd = sdram_timing_pkg::CMD_PRE;
        `SDT_ENC_READ: cmd = sdram_timing_pkg::CMD_READ;
        `SDT_ENC_WRITE: cmd = sdram_timing_pkg::CMD_WRITE;
        // refresh with clock enable falling enters self refresh
        `SDT_ENC_REFRESH: cmd = i_cke ? sdram_timing_pkg::CMD_REFRESH : sdram_timing_pkg::CMD_SELF_REF;
        `SDT_ENC_MODE: cmd = sdram_timing_pkg::CMD_MODE;
        default: cmd = sdram_timing_pkg::CMD_NOP;
      endcase
    end
  end

  // self refresh holds until clock enable returns high
  always_ff @(posedge i_clk_link) begin
    if (lrst) begin
      self_ref_q <= 1'b0;
    end else if (cmd == sdram_timing_pkg::CMD_SELF_REF) begin
      self_ref_q <= 1'b1;
    end else if (i_cke) begin
      self_ref_q <= 1'b0;
    end
  end

  // mode register; unsupported latencies and full page keep the old setting
  always_ff @(posedge i_clk_link) begin
    if (lrst) begin
      bl_code_q <= `SDT_RST_BL_CODE;
      ilv_q <= `SDT_RST_INTERLEAVE;
      cl3_q <= `SDT_RST_CL3;
    end else if (cmd == sdram_timing_pkg::CMD_MODE) begin
      if (!i_cmd.addr[`SDT_MODE_BL_MSB]) begin
        bl_code_q <= i_cmd.addr[`SDT_MODE_BL_MSB-1:`SDT_MODE_BL_LSB];
      end
      ilv_q <= i_cmd.addr[`SDT_MODE_BT_BIT];
      if (i_cmd.addr[`SDT_MODE_CL_MSB:`SDT_MODE_CL_LSB] == `SDT_CL_THREE) begin
        cl3_q <= 1'b1;
      end else if (i_cmd.addr[`SDT_MODE_CL_MSB:`SDT_MODE_CL_LSB] == `SDT_CL_TWO) begin
        cl3_q <= 1'b0;
      end
    end
  end

  // beat selection: a column command always starts a fresh burst
  always_comb begin
    is_col = (cmd == sdram_timing_pkg::CMD_READ) || (cmd == sdram_timing_pkg::CMD_WRITE);
    term = (cmd == sdram_timing_pkg::CMD_PRE) && (i_cmd.addr[`SDT_AP_BIT] || (i_cmd.bank == burst_bank_q));
    beat_v = 1'b0;
    beat_wr = 1'b0;
    beat_idx = 4'h0;
    if (is_col) begin
      beat_v = 1'b1;
      beat_wr = (cmd == sdram_timing_pkg::CMD_WRITE);
      beat_idx = {i_cmd.bank, i_cmd.addr[`SDT_COL_MSB:0]};
    end else if (clk_act && (burst_left_q != 4'h0) && !term) begin
      beat_v = 1'b1;
      beat_wr = burst_wr_q;
      beat_idx = {burst_bank_q, burst_col(start_col_q, burst_cnt_q, bl_code_q, ilv_q)};
    end
  end

  // burst counter; frozen while the internal clock is suspended
  always_ff @(posedge i_clk_link) begin
    if (lrst) begin
      burst_left_q <= 4'h0;
      burst_cnt_q <= 3'h0;
      start_col_q <= 3'h0;
      burst_bank_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_ap_q <= 1'b0;
    end else if (is_col) begin
      burst_left_q <= 4'(burst_len(bl_code_q) - 4'h1);
      burst_cnt_q <= 3'h1;
      start_col_q <= i_cmd.addr[`SDT_COL_MSB:0];
      burst_bank_q <= i_cmd.bank;
      burst_wr_q <= (cmd == sdram_timing_pkg::CMD_WRITE);
      burst_ap_q <= i_cmd.addr[`SDT_AP_BIT];
    end else if (clk_act && (burst_left_q != 4'h0)) begin
      burst_left_q <= term ? 4'h0 : 4'(burst_left_q - 4'h1);
      burst_cnt_q <= 3'(burst_cnt_q + 3'h1);
    end
  end

  // open rows; auto precharge closes the row after the last beat of bursts over one beat, unless an activate, precharge, read or write takes that edge
  always_ff @(posedge i_clk_link) begin
    if (lrst) begin
      bank_open_q <= 2'h0;
    end else if (cmd == sdram_timing_pkg::CMD_ACT) begin
      bank_open_q[i_cmd.bank] <= 1'b1;
    end else if (cmd == sdram_timing_pkg::CMD_PRE) begin
      if (i_cmd.addr[`SDT_AP_BIT]) begin
        bank_open_q <= 2'h0;
      end else begin
        bank_open_q[i_cmd.bank] <= 1'b0;
      end
    end else if (clk_act && burst_ap_q && (burst_left_q == 4'h1) && !is_col) begin
      bank_open_q[burst_bank_q] <= 1'b0;
    end
  end

  // write beats land on their own edge, masked bytes keep old data
  always_ff @(posedge i_clk_link) begin
    if (beat_v && beat_wr) begin
      for (int b = 0; b < 8; b++) begin
        if (!i_dqm[b]) begin
          mem_q[beat_idx][b*8 +: 8] <= i_dq_i[b*8 +: 8];
        end
      end
    end
  end

  // read delay line; a precharged burst simply stops feeding it
  always_ff @(posedge i_clk_link) begin
    if (lrst) begin
      pipe_v_q <= 2'h0;
      pipe_idx_q[0] <= 4'h0;
      pipe_idx_q[1] <= 4'h0;
    end else if (clk_act) begin
      pipe_v_q <= {pipe_v_q[0], beat_v && !beat_wr};
      pipe_idx_q[0] <= beat_idx;
      pipe_idx_q[1] <= pipe_idx_q[0];
    end
  end

  // latency two takes the first stage, latency three the second
  assign tap_v = cl3_q ? pipe_v_q[1] : pipe_v_q[0];
  assign tap_idx = cl3_q ? pipe_idx_q[1] : pipe_idx_q[0];

  // byte masks are delayed one edge so the pins follow two edges later
  always_ff @(posedge i_clk_link) begin
    if (lrst) begin
      dqm_q <= 8'hFF;
    end else if (clk_act) begin
      dqm_q <= i_dqm;
    end
  end

  // output data and per byte enables, released while idle
  always_ff @(posedge i_clk_link) begin
    if (lrst) begin
      o_dq_o <= 64'h0;
      o_dq_oe_n <= 8'hFF;
    end else if (clk_act) begin
      o_dq_o <= mem_q[tap_idx];
      for (int b = 0; b < 8; b++) begin
        o_dq_oe_n[b] <= !(tap_v && !dqm_q[b]);
      end
    end
  end

  // event toggle for the system side; a level is safe to synchronise
  always_ff @(posedge i_clk_link) begin
    if (lrst) begin
      cmd_tgl_q <= 1'b0;
    end else if (cmd != sdram_timing_pkg::CMD_NOP) begin
      cmd_tgl_q <= !cmd_tgl_q;
    end
  end

  assign stat_link = '{bank_open: bank_open_q, self_ref: self_ref_q, cl3: cl3_q, cmd_tgl: cmd_tgl_q};

  // status levels cross into the system clock
  sdram_cdc_sync #(.WIDTH(5)) u_stat_sync (
    .i_clk(i_clk_sys),
    .i_rst(i_sys_rst),
    .i_d(stat_link),
    .o_q(stat_sys)
  );

  // toggle edge becomes a one cycle pulse after the synchroniser
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tgl_old_q <= 1'b0;
    end else begin
      tgl_old_q <= stat_sys.cmd_tgl;
    end
  end
  assign o_cmd_pulse = stat_sys.cmd_tgl ^ tgl_old_q;
  assign o_bank_open = stat_sys.bank_open;
  assign o_self_ref = stat_sys.self_ref;
  assign o_cl3 = stat_sys.cl3;

  // helper state for the checks below
  always_ff @(posedge i_clk_link) begin
    chk_idx_q <= beat_idx;
    chk_old_q <= mem_q[beat_idx][7:0];
    chk_din_q <= i_dq_i[7:0];
    chk_bank_q <= i_cmd.bank;
  end

  row_open_a: assert property (@(posedge i_clk_link) disable iff (lrst)
    (cmd == sdram_timing_pkg::CMD_ACT) |=> bank_open_q[chk_bank_q])
    else $error("activated bank not open");

  burst_restart_a: assert property (@(posedge i_clk_link) disable iff (lrst)
    (is_col && (burst_left_q != 4'h0)) |=> (burst_left_q == 4'(burst_len(bl_code_q) - 4'h1)) && (burst_cnt_q == 3'h1))
    else $error("interrupting column command did not restart burst");

  cs_ignore_a: assert property (@(posedge i_clk_link) disable iff (lrst)
    (i_cmd.cs_n && (burst_left_q == 4'h0)) |=> $stable(bank_open_q) && $stable(cl3_q) && (burst_left_q == 4'h0))
    else $error("deselected edge changed state");

  cke_suspend_a: assert property (@(posedge i_clk_link) disable iff (lrst)
    (!i_cke && !is_col) |-> ##2 ($stable(burst_left_q) && $stable(o_dq_oe_n)))
    else $error("suspended clock still advanced");

  wr_mask_a: assert property (@(posedge i_clk_link) disable iff (lrst)
    (beat_v && beat_wr && i_dqm[0]) |=> (mem_q[chk_idx_q][7:0] == chk_old_q))
    else $error("masked write byte changed");

  rd_mask_a: assert property (@(posedge i_clk_link) disable iff (lrst)
    (i_dqm[1] && clk_act && i_cke) |-> ##2 o_dq_oe_n[1])
    else $error("masked read byte driven");

  pre_release_a: assert property (@(posedge i_clk_link) disable iff (lrst)
    ((cmd == sdram_timing_pkg::CMD_PRE) && i_cmd.addr[`SDT_AP_BIT] && i_cke ##1 i_cke ##1 (i_cke || !cl3_q))
    |-> if (cl3_q) ##1 (&o_dq_oe_n) else (&o_dq_oe_n))
    else $error("outputs not released after precharge");

  wr_latency_a: assert property (@(posedge i_clk_link) disable iff (lrst)
    ((cmd == sdram_timing_pkg::CMD_WRITE) && !i_dqm[0]) |=> (mem_q[chk_idx_q][7:0] == chk_din_q))
    else $error("first write word not captured on command edge");

endmodule : sdram_command_timing

// *** sdram_host_model.sv ***
// host controller model driving the command, mask and data pins of the link
`include "sdram_timing_regs.svh"
module sdram_host_model #(
  parameter int T_CK_NS = 80 // period above both latency floors
) (
  // link clock
  input wire logic i_clk_link,
  // pins toward the device
  output sdram_timing_pkg::link_cmd_type o_cmd,
  output logic o_cke,
  output logic [7:0] o_dqm,
  output logic [63:0] o_dq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ns minimums rounded up to whole link cycles
  localparam int T_RAS = (72 + T_CK_NS - 1) / T_CK_NS;
  localparam int T_RC = (108 + T_CK_NS - 1) / T_CK_NS;
  localparam int T_RCD = (30 + T_CK_NS - 1) / T_CK_NS;
  localparam int T_RP = (36 + T_CK_NS - 1) / T_CK_NS;
  localparam int T_RRD = (24 + T_CK_NS - 1) / T_CK_NS;
  localparam int T_APW = (60 + T_CK_NS - 1) / T_CK_NS;
  localparam int T_WR = (20 + T_CK_NS - 1) / T_CK_NS;
  // link edge count and stamps of past commands, per bank where it matters
  int cyc = 0;
  int act_at [2] = '{-99, -99};
  int ref_at = -99;
  int pre_at = -99;
  int wr_at = -99;
  always @(posedge i_clk_link) cyc <= cyc + 1;
  // idle pins: deselected, clock enabled
  initial begin
    o_cmd = 16'hF000;
    o_cke = 1'b1;
    o_dqm = 8'h00;
    o_dq = 64'h0;
  end
  function automatic int mx(input int x, input int y);
    return (x > y) ? x : y;
  endfunction : mx
  // one command at a falling edge; hold keeps it so another can follow back to back
  task automatic go(input logic [3:0] c, input logic b, input logic [10:0] a,
                    input logic [63:0] d, input logic [7:0] m, input bit hold);
    int t;
    t = cyc;
    if (!c[3] && (c[2:0] == `SDT_ENC_ACT || c[2:0] <= `SDT_ENC_REFRESH)) begin
      t = mx(mx(t, ref_at + T_RC), mx(pre_at + T_RP, wr_at + T_APW));
      t = mx(t, act_at[~b] + T_RRD);
      ref_at = t;
      if (c[2:0] == `SDT_ENC_ACT) act_at[b] = t;
    end else if (!c[3] && c[2:0] >= `SDT_ENC_WRITE) begin
      t = mx(mx(t, wr_at + 1), act_at[b] + (a[`SDT_AP_BIT] ? T_RAS : T_RCD));
    end else if (!c[3] && c[2:0] == `SDT_ENC_PRE) begin
      t = mx(mx(t, act_at[b] + T_RAS), wr_at + T_WR);
      pre_at = t;
    end
    while (cyc < t) @(posedge i_clk_link);
    @(negedge i_clk_link);
    o_cmd <= {c, b, a};
    o_dqm <= m;
    o_dq <= (c[2:0] == `SDT_ENC_WRITE) ? d : ~o_dq;
    o_cke <= 1'b1; // resume edge refuses this one; the next comes a full period later
    @(posedge i_clk_link);
    if (!hold) begin
      @(negedge i_clk_link);
      o_cmd <= 16'hF000;
      o_dqm <= 8'h00;
      o_dq <= ~o_dq; // released lines never keep the old word
    end
  endtask : go
  // two beat write; the second word follows on the next edge
  task automatic write2(input logic b, input logic [2:0] col, input logic [63:0] w0,
                        input logic [63:0] w1, input logic [7:0] m0);
    go({1'b0, `SDT_ENC_WRITE}, b, {8'h00, col}, w0, m0, 1'b1);
    @(negedge i_clk_link);
    o_cmd <= 16'hF000;
    o_dq <= w1;
    o_dqm <= 8'h00;
    @(negedge i_clk_link);
    wr_at = cyc - 1;
    o_dq <= ~w1;
  endtask : write2
  // clock suspend from the next edge
  task automatic suspend();
    @(negedge i_clk_link);
    o_cke <= 1'b0;
    @(posedge i_clk_link);
  endtask : suspend
  // refresh with clock enable falling enters self refresh; the next go call raises it again
  task automatic self_refresh();
    int t;
    t = mx(mx(cyc, ref_at + T_RC), mx(pre_at + T_RP, wr_at + T_APW));
    ref_at = t;
    while (cyc < t) @(posedge i_clk_link);
    @(negedge i_clk_link);
    o_cmd <= {1'b0, `SDT_ENC_REFRESH, 1'b0, 11'h000};
    o_cke <= 1'b0;
    @(negedge i_clk_link);
    o_cmd <= 16'hF000;
  endtask : self_refresh
endmodule : sdram_host_model

// *** sdram_command_timing_bench.sv ***
// self-checking bench for the sdram command timing block
`include "sdram_timing_regs.svh"
module sdram_command_timing_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // clocks, reset and link pins
  logic i_clk_sys = 1'b0;
  logic i_clk_link = 1'b0;
  logic i_sys_rst = 1'b1;
  sdram_timing_pkg::link_cmd_type cmd;
  logic cke;
  logic [7:0] dqm;
  logic [63:0] dq_i;
  logic [63:0] dq_o;
  logic [7:0] dq_oe_n;
  logic [1:0] bank_open;
  logic self_ref;
  logic cl3;
  logic cmd_pulse;
  int mismatches = 0;
  int checks_done = 0;
  int pulses = 0;
  // data patterns
  localparam logic [63:0] W0 = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] W1 = 64'hFEDC_BA98_7654_3210;
  sdram_command_timing sdram_command_timing_inst (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_link(i_clk_link), .i_cke(cke),
    .i_cmd(cmd), .i_dqm(dqm), .i_dq_i(dq_i), .o_dq_o(dq_o), .o_dq_oe_n(dq_oe_n),
    .o_bank_open(bank_open), .o_self_ref(self_ref), .o_cl3(cl3), .o_cmd_pulse(cmd_pulse)
  );
  sdram_host_model #(.T_CK_NS(80)) sdram_host_model_inst (
    .i_clk_link(i_clk_link), .o_cmd(cmd), .o_cke(cke), .o_dqm(dqm), .o_dq(dq_i)
  );
  // system clock 8 ns, link clock 80 ns with its own phase
  initial begin
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #3;
    forever #40 i_clk_link = ~i_clk_link;
  end
  // count command pulses seen in the system domain
  always @(posedge i_clk_sys) if (cmd_pulse === 1'b1) pulses++;
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic issue(input logic [3:0] c, input logic b, input logic [10:0] a, input logic [7:0] m, input bit h);
    sdram_host_model_inst.go(c, b, a, 64'h0, m, h);
  endtask : issue
  // read two beats and judge data, enables and release
  task automatic read2(input logic b, input logic [2:0] col, input int cl, input logic [7:0] m,
                       input logic [63:0] e0, input logic [63:0] e1);
    issue({1'b0, `SDT_ENC_READ}, b, {8'h00, col}, m, 1'b0);
    repeat (cl - 1) @(negedge i_clk_link);
    if (m == 8'h00) check("read beat 0", e0, dq_o);
    check("enable beat 0", {56'h0, m}, {56'h0, dq_oe_n});
    @(negedge i_clk_link);
    check("read beat 1", e1, dq_o);
    check("enable beat 1", 64'h0, {56'h0, dq_oe_n});
    @(negedge i_clk_link);
    check("enable after burst", 64'hFF, {56'h0, dq_oe_n});
  endtask : read2
  // mode load, write, read back at a given latency
  task automatic sc_basic(input int cl);
    issue({1'b0, `SDT_ENC_MODE}, 1'b0, {4'h0, cl[2:0], 1'b0, 3'h1}, 8'h00, 1'b0);
    issue({1'b0, `SDT_ENC_ACT}, 1'b0, 11'h005, 8'h00, 1'b0);
    sdram_host_model_inst.write2(1'b0, 3'h0, W0, W1, 8'h00);
    read2(1'b0, 3'h0, cl, 8'h00, W0, W1);
    check("latency flag", {63'h0, cl == 3}, {63'h0, cl3});
    check("bank open", 64'h1, {62'h0, bank_open});
    issue({1'b0, `SDT_ENC_PRE}, 1'b0, 11'h400, 8'h00, 1'b0);
  endtask : sc_basic
  // byte inhibit on write data now, on read data two edges on
  task automatic sc_mask();
    issue({1'b0, `SDT_ENC_ACT}, 1'b1, 11'h009, 8'h00, 1'b0);
    sdram_host_model_inst.write2(1'b1, 3'h2, W0, W0, 8'h00);
    sdram_host_model_inst.write2(1'b1, 3'h2, W1, W0, 8'h01);
    read2(1'b1, 3'h2, 2, 8'h82, 64'h0, W0);
    read2(1'b1, 3'h2, 2, 8'h00, {W1[63:8], W0[7:0]}, W0);
  endtask : sc_mask
  // second read one edge later replaces the first burst
  task automatic sc_interrupt();
    issue({1'b0, `SDT_ENC_READ}, 1'b1, 11'h003, 8'h00, 1'b1);
    read2(1'b1, 3'h2, 2, 8'h00, {W1[63:8], W0[7:0]}, W0);
  endtask : sc_interrupt
  // deselected and suspended reads are ignored
  task automatic sc_ignored();
    issue({1'b1, `SDT_ENC_READ}, 1'b1, 11'h002, 8'h00, 1'b0);
    repeat (3) begin
      @(negedge i_clk_link);
      check("deselected read", 64'hFF, {56'h0, dq_oe_n});
    end
    sdram_host_model_inst.suspend();
    issue({1'b0, `SDT_ENC_READ}, 1'b1, 11'h002, 8'h00, 1'b0);
    repeat (3) begin
      @(negedge i_clk_link);
      check("suspended read", 64'hFF, {56'h0, dq_oe_n});
    end
  endtask : sc_ignored
  // precharge one edge after a read cuts the burst
  task automatic sc_cut();
    issue({1'b0, `SDT_ENC_READ}, 1'b1, 11'h002, 8'h00, 1'b1);
    issue({1'b0, `SDT_ENC_PRE}, 1'b1, 11'h000, 8'h00, 1'b0);
    check("beat before cut", {W1[63:8], W0[7:0]}, dq_o);
    @(negedge i_clk_link);
    check("released by cut", 64'hFF, {56'h0, dq_oe_n});
    @(negedge i_clk_link);
    check("banks closed", 64'h0, {62'h0, bank_open});
  endtask : sc_cut
  // self refresh entry with clock enable low, exit when it returns
  task automatic sc_self_refresh();
    sdram_host_model_inst.self_refresh();
    repeat (2) @(negedge i_clk_link);
    check("self refresh entered", 64'h1, {63'h0, self_ref});
    issue({1'b1, `SDT_ENC_READ}, 1'b0, 11'h000, 8'h00, 1'b0);
    repeat (2) @(negedge i_clk_link);
    check("self refresh left", 64'h0, {63'h0, self_ref});
  endtask : sc_self_refresh
  task automatic tally_and_finish();
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // watchdog well beyond the hundred or so link cycles the run needs
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
  // main sequence; reset spans five link edges so the link side sees it
  initial begin
    repeat (48) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    repeat (4) @(posedge i_clk_link);
    sc_basic(3);
    sc_basic(2);
    sc_mask();
    sc_interrupt();
    sc_ignored();
    sc_cut();
    sc_self_refresh();
    check("self refresh", 64'h0, {63'h0, self_ref});
    check("command pulses", 64'h1, {63'h0, pulses > 0});
    tally_and_finish();
  end
endmodule : sdram_command_timing_bench
